// ===== verilog/tlq_consts.vh
// tlq_consts.vh: offsets, field positions, codes and reset values of the
// tessellation level quantizer.
// assumes: included by bare name from every design file of the block.
`ifndef TLQ_CONSTS_VH
`define TLQ_CONSTS_VH

// ==========================================================================
// register byte addresses
`define TLQ_OFS_CTRL       8'h00
`define TLQ_OFS_DEF_OUTER0 8'h04
`define TLQ_OFS_DEF_OUTER1 8'h08
`define TLQ_OFS_DEF_OUTER2 8'h0C
`define TLQ_OFS_DEF_OUTER3 8'h10
`define TLQ_OFS_DEF_INNER0 8'h14
`define TLQ_OFS_DEF_INNER1 8'h18
`define TLQ_OFS_STATUS     8'h1C
`define TLQ_OFS_CNT_EMIT   8'h20
`define TLQ_OFS_CNT_CULL   8'h24

// ==========================================================================
// control register fields
`define TLQ_CTRL_EVAL_BIT   0
`define TLQ_CTRL_CTLSTG_BIT 1
`define TLQ_CTRL_MODE_LSB   2
`define TLQ_CTRL_SPACE_LSB  4
`define TLQ_CTRL_WDECL_BIT  6
`define TLQ_CTRL_CW_BIT     7
`define TLQ_CTRL_POINT_BIT  8
`define TLQ_CTRL_WIDTH      9

// ==========================================================================
// reset values
`define TLQ_RST_CTRL       9'h000
`define TLQ_RST_LEVEL      32'h3F80_0000

// ==========================================================================
// domain modes and spacing policies
`define TLQ_MODE_TRI       2'h0
`define TLQ_MODE_QUAD      2'h1
`define TLQ_MODE_LINES     2'h2
`define TLQ_SPACE_EQUAL    2'h0
`define TLQ_SPACE_EVEN     2'h1
`define TLQ_SPACE_ODD      2'h2
`define TLQ_SPACE_NONE     2'h3

`endif

// ===== verilog/tlq_level_quant.v
// tlq_level_quant.v: one level word to a segment count and short length.
// assumes: purely combinational; the caller registers its results.
`timescale 1ns/1ns
`include "tlq_consts.vh"

module tlq_level_quant #(
    parameter IW = 8,
    parameter FB = 8
) (
    input  wire [31:0]   level_word,
    input  wire [1:0]    spacing,
    input  wire [IW-1:0] max_subdivision_level,
    output reg  [IW-1:0] seg_n,
    output reg  [FB:0]   short_len,
    output wire          le_zero,
    output wire          is_nan
);
    localparam W = IW + FB;
    localparam integer BIAS_SH = 150 - FB;

    wire        sgn = level_word[31];
    wire [7:0]  ex  = level_word[30:23];
    wire [23:0] man = {(|ex), level_word[22:0]};

    assign is_nan  = (ex == 8'hFF) && (|level_word[22:0]);
    assign le_zero = sgn || (level_word[30:0] == 31'h0000_0000);

    reg [W+23:0] wide;
    reg [W-1:0]  fx;
    reg [W-1:0]  lo;
    reg [W-1:0]  hi;
    reg [W-1:0]  fc;
    reg [IW:0]   nc;
    reg [W:0]    diff;
    reg [IW-1:0] nm2;
    reg          sticky;
    integer      sh;

    // ======================================================================
    // float to fixed, rounded toward plus so a later ceiling stays honest
    always @* begin
        wide   = {(W+24){1'b0}};
        fx     = {W{1'b0}};
        sticky = 1'b0;
        sh     = 0;
        if (sgn) begin
            fx = {W{1'b0}};
        end else if (ex >= 8'd127 + IW) begin
            fx = {W{1'b1}};
        end else if (ex >= BIAS_SH) begin
            sh   = ex - BIAS_SH;
            wide = {{W{1'b0}}, man} << sh;
            fx   = wide[W-1:0];
        end else begin
            sh     = BIAS_SH - ex;
            wide   = {{W{1'b0}}, man} >> sh;
            sticky = (((man >> sh) << sh) != man);
            fx     = wide[W-1:0];
            if (sticky && (fx != {W{1'b1}}))
                fx = fx + 1'b1;
        end
    end

    // ======================================================================
    // clamp, round to the policy's parity, derive the short segment length
    always @* begin
        lo = {{(IW-1){1'b0}}, 1'b1, {FB{1'b0}}};
        if (spacing == `TLQ_SPACE_EVEN)
            lo = {{(IW-2){1'b0}}, 2'b10, {FB{1'b0}}};
        hi = {max_subdivision_level, {FB{1'b0}}};
        if (spacing == `TLQ_SPACE_ODD)
            hi = {max_subdivision_level - 1'b1, {FB{1'b0}}};
        fc = fx;
        if (fc < lo)
            fc = lo;
        if (fc > hi)
            fc = hi;
        nc = {1'b0, fc[W-1:FB]} + {{IW{1'b0}}, (|fc[FB-1:0])};
        if ((spacing == `TLQ_SPACE_EVEN) && nc[0])
            nc = nc + 1'b1;
        if ((spacing == `TLQ_SPACE_ODD) && !nc[0])
            nc = nc + 1'b1;
        seg_n     = nc[IW-1:0];
        nm2       = seg_n - {{(IW-2){1'b0}}, 2'b10};
        diff      = {1'b0, fc} - {1'b0, nm2, {FB{1'b0}}};
        short_len = {1'b1, {FB{1'b0}}};
        // short length depends on f alone, so equal f gives equal edges
        if ((spacing == `TLQ_SPACE_EVEN || spacing == `TLQ_SPACE_ODD) &&
            (seg_n != {{(IW-1){1'b0}}, 1'b1}))
            short_len = diff[FB+1:1];
    end
endmodule // tlq_level_quant

// ===== verilog/tlq_quantizer_top.v
// tlq_quantizer_top.v: per-patch front end of the primitive generator.
// assumes: one clock; upstream and downstream obey valid/ready; software
// uses the plain register port with read data one cycle after the strobe.
//
// Functional notes
// - without an evaluation stage, patches pass through, unsubdivided.
// - triangle, quad and line-strip domain modes are supported.
// - coordinates in [0,1]; triangle ones are barycentric, summing to one.
// - without a control stage, six stored default levels feed every patch.
// - cull when any relevant outer level is zero or negative.
// - cull when an outer level is a NaN; triangle mode ignores the fourth.
// - a culled patch produces nothing downstream.
// - negative inner levels never cull; they clamp to the lower bound.
// - undeclared spacing behaves as uniform integer spacing.
// - uniform spacing clamps to [1,max], rounds up, equal segments.
// - fractional even clamps to [2,max], rounds up to even.
// - fractional odd clamps to [1,max-1], rounds up to odd.
// - fractional n of one is undivided, else n-2 plus two shorter.
// - short segment length falls from full to zero as n-f nears two.
// - short segment placement depends only on the clamped level.
// - triangles follow declared winding; counter-clockwise when undeclared.
// - point mode emits one point per unique vertex.
// - triangle mode ignores second inner and fourth outer level.
`timescale 1ns/1ns
`include "tlq_consts.vh"

module tlq_quantizer_top #(
    parameter IW                    = 8,
    parameter FB                    = 8,
    parameter [IW-1:0] MAX_SUBDIVISION_LEVEL = 8'h40
) (
    input  wire              clk_sys,
    input  wire              sys_rst,
    input  wire [7:0]        reg_addr,
    input  wire [31:0]       reg_wdata,
    input  wire              reg_wr,
    input  wire              reg_rd,
    output reg  [31:0]       reg_rdata,
    input  wire              up_valid,
    output reg               up_ready,
    input  wire [191:0]      up_levels,
    output reg               down_valid,
    input  wire              down_ready,
    output reg               down_bypass,
    output reg  [1:0]        down_mode,
    output reg  [1:0]        down_spacing,
    output reg               down_clockwise_winding,
    output reg               down_points,
    output reg               down_barycentric,
    output reg  [6*IW-1:0]   down_seg,
    output reg  [6*(FB+1)-1:0] down_short
);
    // ======================================================================
    // registers
    reg  [`TLQ_CTRL_WIDTH-1:0] ctrl;
    reg  [31:0]                def_lvl [0:5];
    reg  [15:0]                cnt_emit;
    reg  [15:0]                cnt_cull;
    integer                    i;
    integer                    j;

    wire       c_eval   = ctrl[`TLQ_CTRL_EVAL_BIT];
    wire       c_ctlstg = ctrl[`TLQ_CTRL_CTLSTG_BIT];
    wire [1:0] c_mode   = ctrl[`TLQ_CTRL_MODE_LSB+1:`TLQ_CTRL_MODE_LSB];
    wire [1:0] c_space  = ctrl[`TLQ_CTRL_SPACE_LSB+1:`TLQ_CTRL_SPACE_LSB];
    wire       c_wdecl  = ctrl[`TLQ_CTRL_WDECL_BIT];
    wire       c_cw     = ctrl[`TLQ_CTRL_CW_BIT];
    wire       c_point  = ctrl[`TLQ_CTRL_POINT_BIT];

    // ======================================================================
    // staged patch, configuration captured with it so a mid-stream write
    // cannot tear one patch's settings apart
    reg          a_valid;
    reg  [191:0] a_lvl;
    reg  [1:0]   a_mode;
    reg  [1:0]   a_space;
    reg          a_cw;
    reg          a_point;
    reg          a_bypass;

    wire [6*IW-1:0]     q_seg;
    wire [6*(FB+1)-1:0] q_short;
    wire [5:0]          q_lez;
    wire [5:0]          q_nan;

    wire take    = up_valid && up_ready;
    wire out_free = !down_valid || down_ready;
    wire advance = a_valid && out_free;

    reg  [3:0] relevant;
    reg        cull;
    reg  [5:0] keep;

    // ======================================================================
    // register port
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl <= `TLQ_RST_CTRL;
            for (i = 0; i < 6; i = i + 1)
                def_lvl[i] <= `TLQ_RST_LEVEL;
        end else if (reg_wr) begin
            case (reg_addr)
                `TLQ_OFS_CTRL:       ctrl <= reg_wdata[`TLQ_CTRL_WIDTH-1:0];
                `TLQ_OFS_DEF_OUTER0: def_lvl[0] <= reg_wdata;
                `TLQ_OFS_DEF_OUTER1: def_lvl[1] <= reg_wdata;
                `TLQ_OFS_DEF_OUTER2: def_lvl[2] <= reg_wdata;
                `TLQ_OFS_DEF_OUTER3: def_lvl[3] <= reg_wdata;
                `TLQ_OFS_DEF_INNER0: def_lvl[4] <= reg_wdata;
                `TLQ_OFS_DEF_INNER1: def_lvl[5] <= reg_wdata;
                default: ;
            endcase
        end
    end

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `TLQ_OFS_CTRL:
                    reg_rdata <= {{(32-`TLQ_CTRL_WIDTH){1'b0}}, ctrl};
                `TLQ_OFS_DEF_OUTER0: reg_rdata <= def_lvl[0];
                `TLQ_OFS_DEF_OUTER1: reg_rdata <= def_lvl[1];
                `TLQ_OFS_DEF_OUTER2: reg_rdata <= def_lvl[2];
                `TLQ_OFS_DEF_OUTER3: reg_rdata <= def_lvl[3];
                `TLQ_OFS_DEF_INNER0: reg_rdata <= def_lvl[4];
                `TLQ_OFS_DEF_INNER1: reg_rdata <= def_lvl[5];
                `TLQ_OFS_STATUS:
                    reg_rdata <= {29'h0000_0000, up_ready, down_valid,
                                  a_valid};
                `TLQ_OFS_CNT_EMIT:   reg_rdata <= {16'h0000, cnt_emit};
                `TLQ_OFS_CNT_CULL:   reg_rdata <= {16'h0000, cnt_cull};
                default:             reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ======================================================================
    // input stage: one patch held at a time; ready drops while it is held
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            a_valid  <= 1'b0;
            up_ready <= 1'b0;
            a_lvl    <= 192'h0;
            a_mode   <= `TLQ_MODE_TRI;
            a_space  <= `TLQ_SPACE_EQUAL;
            a_cw     <= 1'b0;
            a_point  <= 1'b0;
            a_bypass <= 1'b0;
        end else begin
            up_ready <= !(a_valid && !advance) && !take;
            if (take) begin
                a_valid <= 1'b1;
                if (c_ctlstg)
                    a_lvl <= up_levels;
                else
                    a_lvl <= {def_lvl[5], def_lvl[4], def_lvl[3],
                              def_lvl[2], def_lvl[1], def_lvl[0]};
                if (c_mode == `TLQ_MODE_QUAD || c_mode == `TLQ_MODE_LINES)
                    a_mode <= c_mode;
                else
                    a_mode <= `TLQ_MODE_TRI;
                if (c_space == `TLQ_SPACE_NONE)
                    a_space <= `TLQ_SPACE_EQUAL;
                else
                    a_space <= c_space;
                a_cw     <= c_wdecl && c_cw;
                a_point  <= c_point;
                a_bypass <= !c_eval;
            end else if (advance) begin
                a_valid <= 1'b0;
            end
        end
    end

    // ======================================================================
    // six quantizers, all clamping against the same fixed maximum
    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_quant
            tlq_level_quant #(
                .IW (IW),
                .FB (FB)
            ) u_quant (
                .level_word            (a_lvl[32*g+31:32*g]),
                .spacing               (a_space),
                .max_subdivision_level (MAX_SUBDIVISION_LEVEL),
                .seg_n                 (q_seg[IW*g+IW-1:IW*g]),
                .short_len             (q_short[(FB+1)*g+FB:(FB+1)*g]),
                .le_zero               (q_lez[g]),
                .is_nan                (q_nan[g])
            );
        end
    endgenerate

    // ======================================================================
    // cull decision; inner levels never take part in it
    always @* begin
        relevant = 4'b0111;
        if (a_mode == `TLQ_MODE_QUAD)
            relevant = 4'b1111;
        if (a_mode == `TLQ_MODE_LINES)
            relevant = 4'b0011;
        cull = (|(q_lez[3:0] & relevant)) ||
               (|(q_nan[3:0] & (relevant | {(a_mode != `TLQ_MODE_TRI),
                                            3'b111})));
        keep = 6'b11_1111;
        if (a_mode == `TLQ_MODE_TRI)
            keep = 6'b01_0111;
    end

    // ======================================================================
    // output stage: a culled patch never reaches the evaluation side
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            down_valid             <= 1'b0;
            down_bypass            <= 1'b0;
            down_mode              <= `TLQ_MODE_TRI;
            down_spacing           <= `TLQ_SPACE_EQUAL;
            down_clockwise_winding <= 1'b0;
            down_points            <= 1'b0;
            down_barycentric       <= 1'b0;
            down_seg               <= {(6*IW){1'b0}};
            down_short             <= {(6*(FB+1)){1'b0}};
            cnt_emit               <= 16'h0000;
            cnt_cull               <= 16'h0000;
        end else begin
            if (advance && !a_bypass && cull) begin
                down_valid <= 1'b0;
                cnt_cull   <= cnt_cull + 1'b1;
            end else if (advance) begin
                down_valid   <= 1'b1;
                cnt_emit     <= cnt_emit + 1'b1;
                down_bypass  <= a_bypass;
                down_mode    <= a_mode;
                down_spacing <= a_space;
                // winding has no meaning for line strips
                down_clockwise_winding <= a_cw &&
                                          (a_mode != `TLQ_MODE_LINES);
                down_points      <= a_point;
                down_barycentric <= (a_mode == `TLQ_MODE_TRI);
                for (j = 0; j < 6; j = j + 1) begin
                    down_seg[IW*j +: IW] <=
                        (keep[j] && !a_bypass) ?
                        q_seg[IW*j +: IW] : {IW{1'b0}};
                    down_short[(FB+1)*j +: FB+1] <=
                        (keep[j] && !a_bypass) ?
                        q_short[(FB+1)*j +: FB+1] :
                        {(FB+1){1'b0}};
                end
            end else if (down_ready) begin
                down_valid <= 1'b0;
            end
        end
    end
endmodule // tlq_quantizer_top

// ===== testbench/tlq_quantizer_top_props.sv
// port checks of the level quantizer top.
// assumes: bound to tlq_quantizer_top; one clock, async high reset.
`timescale 1ns/1ns
`include "tlq_consts.vh"

// ==========================================================================
// checker
module tlq_props #(
    parameter IW = 8,
    parameter FB = 8,
    parameter [IW-1:0] MAX_SUBDIVISION_LEVEL = 8'h40
) (
    input wire logic                clk_sys,
    input wire logic                sys_rst,
    input wire logic                reg_rd,
    input wire logic [31:0]         reg_rdata,
    input wire logic                up_valid,
    input wire logic                up_ready,
    input wire logic                down_valid,
    input wire logic                down_ready,
    input wire logic                down_bypass,
    input wire logic [1:0]          down_mode,
    input wire logic [1:0]          down_spacing,
    input wire logic                down_clockwise_winding,
    input wire logic                down_barycentric,
    input wire logic [6*IW-1:0]     down_seg,
    input wire logic [6*(FB+1)-1:0] down_short
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    wire rel = down_valid && !down_bypass;

    hold_stall_a: assert property (down_valid && !down_ready |=> down_valid
        && $stable(down_seg) && $stable(down_short) && $stable(down_mode))
        else $error("output moved during stall");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data without strobe");
    take_drop_a: assert property (up_valid && up_ready |=> !up_ready)
        else $error("ready stayed after take");
    bypass_zero_a: assert property (down_valid && down_bypass |->
        down_seg == 0 && down_short == 0) else $error("bypass subdivided");
    tri_ignore_a: assert property (rel && down_barycentric |->
        down_seg[5*IW +: IW] == 0 && down_seg[3*IW +: IW] == 0)
        else $error("triangle used unused levels");
    bary_mode_a: assert property (rel |-> down_barycentric ==
        (down_mode != `TLQ_MODE_QUAD && down_mode != `TLQ_MODE_LINES))
        else $error("barycentric flag wrong");
    line_ccw_a: assert property (down_valid &&
        down_mode == `TLQ_MODE_LINES |-> !down_clockwise_winding)
        else $error("winding set in line mode");
    seg_range_a: assert property (rel |-> down_seg[IW-1:0] >= 1 &&
        down_seg[IW-1:0] <= MAX_SUBDIVISION_LEVEL)
        else $error("segment count out of range");
    even_count_a: assert property (rel &&
        down_spacing == `TLQ_SPACE_EVEN |-> !down_seg[0])
        else $error("even spacing gave odd count");
    odd_count_a: assert property (rel &&
        down_spacing == `TLQ_SPACE_ODD |-> down_seg[0])
        else $error("odd spacing gave even count");
    equal_full_a: assert property (rel &&
        down_spacing == `TLQ_SPACE_EQUAL |-> down_short[FB:0] == (1 << FB))
        else $error("equal spacing short length");
endmodule // tlq_props

bind tlq_quantizer_top tlq_props #(.IW(IW), .FB(FB),
    .MAX_SUBDIVISION_LEVEL(MAX_SUBDIVISION_LEVEL)) i_props (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .up_valid(up_valid), .up_ready(up_ready),
    .down_valid(down_valid), .down_ready(down_ready),
    .down_bypass(down_bypass), .down_mode(down_mode),
    .down_spacing(down_spacing),
    .down_clockwise_winding(down_clockwise_winding),
    .down_barycentric(down_barycentric), .down_seg(down_seg),
    .down_short(down_short));

// ===== testbench/tlq_down_sink.sv
// downstream evaluation stage model: takes results, may stall.
// assumes: driven by the bench clock; slow makes ready toggle.
`timescale 1ns/1ns

// ==========================================================================
// sink
module tlq_down_sink (
    input  wire        clk_sys,
    input  wire        sys_rst,
    input  wire        slow,
    input  wire        down_valid,
    input  wire [7:0]  flags,
    input  wire [47:0] down_seg,
    input  wire [53:0] down_short,
    output reg         down_ready,
    output reg  [31:0] taken,
    output reg  [7:0]  got_flags,
    output reg  [47:0] got_seg,
    output reg  [53:0] got_short
);
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            down_ready <= 1'b0;
            taken      <= 32'h0000_0000;
        end else begin
            // stalls half the time when slow, to test result holding
            down_ready <= slow ? !down_ready : 1'b1;
            if (down_valid && down_ready) begin
                taken     <= taken + 32'h0000_0001;
                got_flags <= flags;
                got_seg   <= down_seg;
                got_short <= down_short;
            end
        end
    end
endmodule // tlq_down_sink

// ===== testbench/tlq_quantizer_top_bench.sv
// self-checking bench of the level quantizer top.
// assumes: the sink model and the bound checker compile beside it.
`timescale 1ns/1ns
`include "tlq_consts.vh"

module tlq_quantizer_top_bench;
    localparam F0 = 32'h0000_0000, F1 = 32'h3F80_0000, F3 = 32'h4040_0000;
    localparam F25 = 32'h4020_0000, FH = 32'h42C8_0000;
    localparam FN1 = 32'hBF80_0000, FNAN = 32'h7FC0_0000;
    reg          clk_sys = 1'b0;
    reg          sys_rst = 1'b1;
    reg  [7:0]   reg_addr = 8'h00;
    reg  [31:0]  reg_wdata = 32'h0000_0000;
    reg          reg_wr = 1'b0, reg_rd = 1'b0, up_valid = 1'b0, slow = 1'b0;
    reg  [191:0] up_levels = 192'h0;
    wire [31:0]  reg_rdata, taken;
    wire         up_ready, down_valid, down_ready, down_bypass, down_cw;
    wire         down_points, down_bary;
    wire [1:0]   down_mode, down_spacing;
    wire [47:0]  down_seg, got_seg;
    wire [53:0]  down_short, got_short;
    wire [7:0]   got_flags;
    wire [7:0]   flags = {down_bypass, down_mode, down_spacing, down_cw,
                          down_points, down_bary};
    integer      fails = 0, compares = 0, m;

    always #5 clk_sys = ~clk_sys;

    tlq_quantizer_top i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .up_valid(up_valid),
        .up_ready(up_ready), .up_levels(up_levels),
        .down_valid(down_valid), .down_ready(down_ready),
        .down_bypass(down_bypass), .down_mode(down_mode),
        .down_spacing(down_spacing), .down_clockwise_winding(down_cw),
        .down_points(down_points), .down_barycentric(down_bary),
        .down_seg(down_seg), .down_short(down_short));
    tlq_down_sink i_sink (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .slow(slow), .down_valid(down_valid), .flags(flags),
        .down_seg(down_seg), .down_short(down_short),
        .down_ready(down_ready), .taken(taken), .got_flags(got_flags),
        .got_seg(got_seg), .got_short(got_short));

    // ======================================================================
    // shared tasks
    task complete_run;
        begin
            $display("compares %0d fails %0d", compares, fails);
            if (fails == 0 && compares > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task chk(input [8*10:1] what, input [31:0] exp, input [31:0] got);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("Error %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk_sys);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge clk_sys);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [31:0] exp);
        begin
            @(posedge clk_sys);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge clk_sys);
            reg_rd <= 1'b0;
            #1 chk("reg_rdata", exp, reg_rdata);
        end
    endtask
    // culled patches get a fixed quiet window instead of an answer
    task patch(input [191:0] lv, input culled);
        integer n;
        reg [31:0] t0;
        begin
            t0 = taken;
            @(posedge clk_sys);
            up_levels <= lv;
            up_valid <= 1'b1;
            n = 0;
            @(posedge clk_sys);
            while (!up_ready && n < 50) begin
                @(posedge clk_sys);
                n = n + 1;
            end
            chk("up_ready", 32'h0000_0001, up_ready);
            if (!up_ready)
                complete_run;
            up_valid <= 1'b0;
            while (taken == t0 && n < 70) begin
                @(posedge clk_sys);
                n = n + 1;
            end
            #1 chk("taken", culled ? t0 : t0 + 1, taken);
            if (n >= 70 && !culled)
                complete_run;
        end
    endtask
    function [31:0] ctl(input [1:0] md, input [1:0] sp, input [2:0] f);
        ctl = {23'h0, f, sp, md, 2'h3};
    endfunction
    function [191:0] lv(input [31:0] a, b, c, d, e, f);
        lv = {f, e, d, c, b, a};
    endfunction

    // ======================================================================
    // scenarios
    task t_regs;
        begin
            rd(`TLQ_OFS_CTRL, 32'h0000_0000);
            rd(`TLQ_OFS_DEF_OUTER0, `TLQ_RST_LEVEL);
            rd(`TLQ_OFS_DEF_INNER1, `TLQ_RST_LEVEL);
            wr(`TLQ_OFS_CNT_CULL, 32'h0000_0005);
            rd(`TLQ_OFS_CNT_CULL, 32'h0000_0000);
            rd(8'h40, 32'h0000_0000);
            $display("regs done");
        end
    endtask
    task t_bypass;
        begin
            patch(192'h0, 1'b0);
            chk("bypass", 32'h0000_0001, got_flags[7]);
            $display("bypass done");
        end
    endtask
    task t_spacing;
        reg [31:0] e0, e1, ei, es;
        begin
            for (m = 0; m < 4; m = m + 1) begin
                wr(`TLQ_OFS_CTRL, ctl(`TLQ_MODE_QUAD, m, 3'h0));
                patch(lv(F25, FH, F1, F3, FN1, F25), 1'b0);
                e0 = (m == 1) ? 4 : 3;
                e1 = (m == 2) ? 63 : 64;
                ei = (m == 1) ? 2 : 1;
                es = (m == 1) ? 64 : (m == 2) ? 192 : 256;
                chk("seg_o0", e0, got_seg[7:0]);
                chk("seg_o1", e1, got_seg[15:8]);
                chk("seg_i0", ei, got_seg[39:32]);
                chk("short_o0", es, got_short[8:0]);
                chk("short_i0", 256, got_short[44:36]);
                chk("short_i1", es, got_short[53:45]);
                chk("spacing", m % 3, got_flags[4:3]);
            end
            $display("spacing done");
        end
    endtask
    task t_cull;
        begin
            wr(`TLQ_OFS_CTRL, ctl(`TLQ_MODE_TRI, 2'h0, 3'h0));
            patch(lv(F1, F1, F1, F0, F1, F0), 1'b0);
            wr(`TLQ_OFS_CTRL, ctl(`TLQ_MODE_QUAD, 2'h0, 3'h0));
            patch(lv(F1, F1, F1, F0, F1, F0), 1'b1);
            patch(lv(F1, FNAN, F1, F1, F1, F1), 1'b1);
            wr(`TLQ_OFS_CTRL, ctl(`TLQ_MODE_LINES, 2'h0, 3'h0));
            patch(lv(F1, F1, FN1, F0, FN1, F1), 1'b0);
            rd(`TLQ_OFS_CNT_CULL, 32'h0000_0002);
            $display("cull done");
        end
    endtask
    task t_defaults;
        begin
            wr(`TLQ_OFS_CTRL, 32'h0000_0001);
            wr(`TLQ_OFS_DEF_OUTER0, F3);
            wr(`TLQ_OFS_DEF_INNER0, F25);
            rd(`TLQ_OFS_DEF_OUTER0, F3);
            patch(192'h0, 1'b0);
            chk("seg_o0", 3, got_seg[7:0]);
            chk("seg_o1", 1, got_seg[15:8]);
            chk("seg_i0", 3, got_seg[39:32]);
            $display("defaults done");
        end
    endtask
    task t_flags;
        begin
            slow <= 1'b1;
            for (m = 0; m < 3; m = m + 1) begin
                wr(`TLQ_OFS_CTRL, ctl(m, 2'h0, {m[0], 2'h3}));
                patch(lv(F3, F3, F3, F3, F3, F3), 1'b0);
                chk("flags", {1'b0, m[1:0], 2'h0, m != 2, m[0], m == 0},
                    got_flags);
            end
            wr(`TLQ_OFS_CTRL, ctl(`TLQ_MODE_QUAD, 2'h0, 3'h2));
            patch(lv(F3, F3, F3, F3, F3, F3), 1'b0);
            chk("cw_undecl", 0, got_flags[2]);
            wr(`TLQ_OFS_CTRL, ctl(2'h3, 2'h0, 3'h0));
            patch(lv(F3, F3, F3, F3, F3, F3), 1'b0);
            chk("mode3", 32'h0000_0001, got_flags);
            slow <= 1'b0;
            $display("flags done");
        end
    endtask

    initial begin
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_regs;
        t_bypass;
        t_spacing;
        t_cull;
        t_defaults;
        t_flags;
        complete_run;
    end
endmodule // tlq_quantizer_top_bench
